/* hps_pkg.sv */
// Shared constants, state codes and helpers for the host-side pin function select block.
`default_nettype none
package hps_pkg;

   // Core clock rate and period.
   localparam int unsigned CORE_CLK_MHZ = 125;
   localparam int unsigned CORE_PER_NS = 1000 / CORE_CLK_MHZ;

   // Receive clock periods driven in PHY MII mode: 25 MHz and 2.5 MHz.
   localparam int unsigned RXCLK_PER_100_NS = 40;
   localparam int unsigned RXCLK_PER_10_NS = 400;

   // Divider terminal counts derived from the periods above.
   localparam logic [5:0] RXCLK_DIV_100 = 6'(RXCLK_PER_100_NS / CORE_PER_NS);
   localparam logic [5:0] RXCLK_DIV_10 = 6'(RXCLK_PER_10_NS / CORE_PER_NS);

   // Strap levels: receive-data-valid high picks PHY MII mode.
   localparam logic STRAP_PHY_LEVEL = 1'h1;
   // Strap levels: serial data output low picks the 50 MHz reference input.
   localparam logic STRAP_REF50_LEVEL = 1'h0;

   // General-purpose pins handled here, and their slot in every vector.
   localparam int GP_N = 5;
   localparam int GP_ZERO = 0;
   localparam int GP_SEVEN = 1;
   localparam int GP_EIGHT = 2;
   localparam int GP_TEN = 3;
   localparam int GP_ELEVEN = 4;

   // Widths of the interrupt status vector and the serial byte.
   localparam int IRQ_W = 16;
   localparam int SER_W = 8;
   localparam logic [2:0] SER_LAST_BIT = 3'h7;

   // Bit positions inside the synchronised pin vector.
   localparam int PIN_N = 7;
   localparam int PIN_SEL = 6;
   localparam int PIN_SCLK = 5;
   localparam int PIN_SDI = 4;
   localparam int PIN_COL = 3;
   localparam int PIN_RXCLK = 2;
   localparam int PIN_RXDV = 1;
   localparam int PIN_SDO = 0;

   // Serial port states, one-hot.
   typedef enum logic [2:0] {
      HPS_SER_IDLE = 3'h1,
      HPS_SER_SHIFT = 3'h2,
      HPS_SER_MIIM = 3'h4
   } hps_ser_e;

   // Rising edge between a held previous sample and the current one.
   function automatic logic hps_rise(input logic prev, input logic cur);
      return !prev && cur;
   endfunction

   // Falling edge between a held previous sample and the current one.
   function automatic logic hps_fall(input logic prev, input logic cur);
      return prev && !cur;
   endfunction

endpackage
`default_nettype wire

/* hps_gpio_if.sv */
// Bundle between the top module and the general-purpose pin bank.
`timescale 1ns/10ps
`default_nettype none
interface hps_gpio_if;
   import hps_pkg::*;
   logic [GP_N-1:0] dir;        // High makes the pin an output.
   logic [GP_N-1:0] src_trig;   // High lets the trigger unit set the level.
   logic [GP_N-1:0] host_out;   // Level the host asks for.
   logic [GP_N-1:0] trig_level; // Trigger unit level, precision-time domain.
   logic [GP_N-1:0] pad_in;     // Raw pin levels.
   logic [GP_N-1:0] level;      // Pin levels synchronised to the core clock.
   logic [GP_N-1:0] level_ptp;  // Pin levels synchronised to the precision-time clock.
   logic [GP_N-1:0] pad_o;      // Registered drive level.
   logic [GP_N-1:0] pad_oe;     // Registered drive enable.
   modport bank (input dir, src_trig, host_out, trig_level, pad_in,
                 output level, level_ptp, pad_o, pad_oe);
   modport ctrl (output dir, src_trig, host_out, trig_level, pad_in,
                 input level, level_ptp, pad_o, pad_oe);
endinterface // hps_gpio_if
`default_nettype wire

/* hps_sync2.sv */
// Two flip-flop level synchroniser.
`timescale 1ns/10ps
`default_nettype none
module hps_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   // First stage; only the second stage reads it.
   logic [W-1:0] meta;

   // No reset: the chain settles two edges after any input change.
   always_ff @(posedge clk) begin
      meta <= d;
      q <= meta;
   end
endmodule // hps_sync2
`default_nettype wire

/* hps_gpio_bank.sv */
// General-purpose pin bank: direction, drive source and two-domain input sampling.
`timescale 1ns/10ps
`default_nettype none
module hps_gpio_bank
   import hps_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ptp_clk,
   hps_gpio_if.bank g
);
   // Trigger levels after crossing into the core domain.
   logic [GP_N-1:0] trig_core;
   // Drive level chosen per pin.
   wire [GP_N-1:0] next_pad_o = (g.src_trig & trig_core) | (~g.src_trig & g.host_out);

   // Host read-back path in the core domain.
   hps_sync2 #(.W(GP_N)) u_in_core (.clk(core_clk), .d(g.pad_in), .q(g.level)); // [R15]

   // Capture units see the pins only after two precision-time flops.
   hps_sync2 #(.W(GP_N)) u_in_ptp (.clk(ptp_clk), .d(g.pad_in), .q(g.level_ptp)); // [R14]

   // Trigger levels change slowly, so a level synchroniser is enough.
   hps_sync2 #(.W(GP_N)) u_trig (.clk(core_clk), .d(g.trig_level), .q(trig_core));

   // Every pin uses the same per-bit logic, so pins zero, eight and eleven match.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         g.pad_o <= '0;
         g.pad_oe <= '0;
      end else begin
         g.pad_o <= next_pad_o; // [R13] [R15] [R16]
         g.pad_oe <= g.dir; // [R13] [R16]
      end
   end
endmodule // hps_gpio_bank
`default_nettype wire

/* hps_top.sv */
// Host-side pin function select: MII pin roles, straps, serial port, interrupt and GPIO.
//
// Overview of operation
// [R1] Collision pin: output in PHY, input in MAC.
// [R2] Receive clock: PHY output, MAC input; 2.5/25 MHz.
// [R3] RMII turns the collision pin into pin ten.
// [R4] RMII turns the receive clock into pin seven.
// [R5] Serial output strap picks crystal or reference clock.
// [R6] MII-only boards never strap the reference clock.
// [R7] Deselected port keeps its data output undriven.
// [R8] Transfers start only on select falling edge.
// [R9] Host clocks data in; device returns on output.
// [R10] MIIM mode: shared clock pin is MDC input.
// [R11] MIIM mode: shared data pin is bidirectional MDIO.
// [R12] Interrupt pin low while any status bit set.
// [R13] General pins serve trigger and capture units.
// [R14] General pin inputs synchronised to precision-time clock.
// [R15] Host sets and reads each general pin.
// [R16] Pins eight and eleven behave like pin zero.
// [R17] Receive-data-valid strap picks PHY or MAC mode.
// [R18] Straps hold from reset release to next reset.
`timescale 1ns/10ps
`default_nettype none
module hps_top
   import hps_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ptp_clk,
   input wire logic rmii_variant,
   input wire logic speed_100,
   output var logic mii_phy_mode,
   output var logic clk_src_ref50,
   input wire logic col_i,
   output var logic col_o,
   output var logic col_oe,
   input wire logic mac_col,
   output var logic col_in_seen,
   input wire logic rx_clk_i,
   output var logic rx_clk_o,
   output var logic rx_clk_oe,
   output var logic rx_clk_in_seen,
   input wire logic rx_dv_i,
   input wire logic serial_slave_select_n,
   input wire logic serial_clk_i,
   input wire logic serial_slave_data_in_i,
   output var logic serial_slave_data_in_o,
   output var logic serial_slave_data_in_oe,
   input wire logic serial_data_out_i,
   output var logic serial_data_out_o,
   output var logic serial_data_out_oe,
   input wire logic miim_mode,
   input wire logic miim_drive,
   input wire logic miim_out,
   output var logic miim_mdc,
   output var logic miim_mdio_in,
   input wire logic [hps_pkg::SER_W-1:0] spi_tx_byte,
   output var logic spi_xfer_start,
   output var logic [hps_pkg::SER_W-1:0] spi_rx_byte,
   output var logic spi_rx_valid,
   input wire logic [hps_pkg::IRQ_W-1:0] irq_status,
   output var logic host_irq_n_o,
   output var logic host_irq_n_oe,
   input wire logic general_pin_zero_i,
   output var logic general_pin_zero_o,
   output var logic general_pin_zero_oe,
   input wire logic general_pin_eight_i,
   output var logic general_pin_eight_o,
   output var logic general_pin_eight_oe,
   input wire logic general_pin_eleven_i,
   output var logic general_pin_eleven_o,
   output var logic general_pin_eleven_oe,
   input wire logic [hps_pkg::GP_N-1:0] gp_dir,
   input wire logic [hps_pkg::GP_N-1:0] gp_src_trig,
   input wire logic [hps_pkg::GP_N-1:0] gp_host_out,
   input wire logic [hps_pkg::GP_N-1:0] gp_trig_level,
   output var logic [hps_pkg::GP_N-1:0] gp_level,
   output var logic [hps_pkg::GP_N-1:0] gp_ptp_level
);
   import hps_pkg::*;

   // Pin levels after the two-flop synchroniser.
   logic [PIN_N-1:0] pin_s;
   // Previous synchronised select and serial clock, for edge detection.
   logic sel_prev;
   logic sclk_prev;
   // Latched RMII operation.
   logic rmii_mode;
   // Serial port state and its next value.
   hps_ser_e ser_state;
   hps_ser_e next_ser_state;
   // Serial bit counter and shift registers.
   logic [2:0] bit_cnt;
   logic [SER_W-1:0] rx_shift;
   logic [SER_W-1:0] tx_shift;
   // Receive clock divider.
   logic [5:0] rx_div_cnt;

   // Bundle towards the pin bank.
   hps_gpio_if gio ();

   // Named views of the synchronised pins.
   wire sel_s = pin_s[PIN_SEL];
   wire sclk_s = pin_s[PIN_SCLK];
   wire sdi_s = pin_s[PIN_SDI];
   // Edge decodes on synchronised samples.
   wire sel_fall = hps_fall(sel_prev, sel_s);
   wire sclk_rise = hps_rise(sclk_prev, sclk_s);
   wire sclk_fall = hps_fall(sclk_prev, sclk_s);
   // State decodes.
   wire in_shift = (ser_state == HPS_SER_SHIFT);
   wire in_miim = (ser_state == HPS_SER_MIIM);
   wire shift_bit = in_shift && sclk_rise;
   wire [SER_W-1:0] rx_next_word = {rx_shift[SER_W-2:0], sdi_s};
   // Pin role decodes.
   wire mii_phy = !rmii_mode && mii_phy_mode;
   wire mii_mac = !rmii_mode && !mii_phy_mode;
   // General pins seven and ten ride on the receive clock and collision pins.
   wire rmii_alt_pin_seven_o = gio.pad_o[GP_SEVEN];
   wire rmii_alt_pin_seven_oe = gio.pad_oe[GP_SEVEN];
   wire rmii_alt_pin_ten_o = gio.pad_o[GP_TEN];
   wire rmii_alt_pin_ten_oe = gio.pad_oe[GP_TEN];
   // Divider terminal count and high half, chosen by line speed.
   wire [5:0] rx_div_top = speed_100 ? RXCLK_DIV_100 : RXCLK_DIV_10;
   wire [5:0] rx_div_half = rx_div_top >> 1;
   wire rx_div_wrap = (rx_div_cnt >= rx_div_top - 6'h01);
   wire [5:0] next_rx_div_cnt = rx_div_wrap ? 6'h00 : rx_div_cnt + 6'h01;
   wire rx_clk_level = (rx_div_cnt < rx_div_half);
   // Any pending interrupt status.
   wire irq_any = |irq_status;

   // Every pin read by logic passes two flops first.
   hps_sync2 #(.W(PIN_N)) u_pin_sync (
      .clk(core_clk),
      .d({serial_slave_select_n, serial_clk_i, serial_slave_data_in_i, col_i,
          rx_clk_i, rx_dv_i, serial_data_out_i}),
      .q(pin_s)
   );

   // Host and trigger controls into the bank.
   assign gio.dir = gp_dir;
   assign gio.src_trig = gp_src_trig;
   assign gio.host_out = gp_host_out;
   assign gio.trig_level = gp_trig_level;
   assign gio.pad_in = {general_pin_eleven_i, col_i, general_pin_eight_i, rx_clk_i,
                        general_pin_zero_i};

   // Direction, drive source and input sampling for all general pins.
   hps_gpio_bank u_bank (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ptp_clk(ptp_clk),
      .g(gio)
   );

   // Read-back levels come straight from synchroniser flops in the bank.
   assign gp_level = gio.level; // [R15]
   assign gp_ptp_level = gio.level_ptp; // [R14]
   // Dedicated general pins come straight from the bank's drive flops.
   assign general_pin_zero_o = gio.pad_o[GP_ZERO]; // [R13]
   assign general_pin_zero_oe = gio.pad_oe[GP_ZERO];
   assign general_pin_eight_o = gio.pad_o[GP_EIGHT]; // [R16]
   assign general_pin_eight_oe = gio.pad_oe[GP_EIGHT];
   assign general_pin_eleven_o = gio.pad_o[GP_ELEVEN]; // [R16]
   assign general_pin_eleven_oe = gio.pad_oe[GP_ELEVEN];

   // Straps follow the pins while reset is held and freeze at release.
   // The pins go on to other duties, so nothing after release may disturb them.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mii_phy_mode <= (pin_s[PIN_RXDV] == STRAP_PHY_LEVEL); // [R17] [R18]
         clk_src_ref50 <= rmii_variant && (pin_s[PIN_SDO] == STRAP_REF50_LEVEL); // [R5] [R6]
         rmii_mode <= rmii_variant; // [R18]
      end
   end

   // Inputs seen in MAC MII mode, handed on as synchronised levels.
   assign col_in_seen = pin_s[PIN_COL]; // [R1]
   assign rx_clk_in_seen = pin_s[PIN_RXCLK]; // [R2]

   // Free-running divider for the receive clock in PHY MII mode.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_div_cnt <= 6'h00;
      end else begin
         rx_div_cnt <= next_rx_div_cnt; // [R2]
      end
   end

   // Collision pin role.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         col_o <= 1'h0;
         col_oe <= 1'h0;
      end else if (rmii_mode) begin
         col_o <= rmii_alt_pin_ten_o; // [R3]
         col_oe <= rmii_alt_pin_ten_oe; // [R3]
      end else begin
         col_o <= mac_col; // [R1]
         col_oe <= mii_phy; // [R1]
      end
   end

   // Receive clock pin role; in MAC mode the pin is only listened to.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_clk_o <= 1'h0;
         rx_clk_oe <= 1'h0;
      end else if (rmii_mode) begin
         rx_clk_o <= rmii_alt_pin_seven_o; // [R4]
         rx_clk_oe <= rmii_alt_pin_seven_oe; // [R4]
      end else begin
         rx_clk_o <= rx_clk_level; // [R2]
         rx_clk_oe <= mii_phy; // [R2]
      end
   end

   // Edge history for the select and serial clock samples.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sel_prev <= 1'h1;
         sclk_prev <= 1'h0;
      end else begin
         sel_prev <= sel_s;
         sclk_prev <= sclk_s;
      end
   end

   // Serial port mode selection; MIIM overrides any byte in flight.
   always_comb begin
      next_ser_state = ser_state;
      unique case (ser_state)
         HPS_SER_IDLE: begin
            if (miim_mode) begin
               next_ser_state = HPS_SER_MIIM; // [R10]
            end else if (sel_fall) begin
               next_ser_state = HPS_SER_SHIFT; // [R8]
            end
         end
         HPS_SER_SHIFT: begin
            if (miim_mode) begin
               next_ser_state = HPS_SER_MIIM;
            end else if (sel_s) begin
               next_ser_state = HPS_SER_IDLE; // [R7]
            end
         end
         HPS_SER_MIIM: begin
            if (!miim_mode) begin
               next_ser_state = HPS_SER_IDLE;
            end
         end
         default: begin
            next_ser_state = HPS_SER_IDLE;
         end
      endcase
   end

   // Serial state register.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ser_state <= HPS_SER_IDLE;
      end else begin
         ser_state <= next_ser_state;
      end
   end

   // Start pulse and bit counter; the count restarts on every select fall.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spi_xfer_start <= 1'h0;
         bit_cnt <= 3'h0;
      end else begin
         spi_xfer_start <= sel_fall && !miim_mode && !in_miim; // [R8]
         if (sel_fall) begin
            bit_cnt <= 3'h0; // [R8]
         end else if (shift_bit) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   // Input bits are taken on serial clock rising edges, first bit highest.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_shift <= '0;
         spi_rx_byte <= '0;
         spi_rx_valid <= 1'h0;
      end else begin
         spi_rx_valid <= shift_bit && (bit_cnt == SER_LAST_BIT); // [R9]
         if (shift_bit) begin
            rx_shift <= rx_next_word; // [R9]
         end
         if (shift_bit && (bit_cnt == SER_LAST_BIT)) begin
            spi_rx_byte <= rx_next_word;
         end
      end
   end

   // Read data leaves on falling edges; a fresh byte loads after each eighth bit.
   // The synchronised clock limits the serial clock to well under a fifth of core_clk.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_shift <= '0;
      end else if (sel_fall) begin
         tx_shift <= spi_tx_byte; // [R9]
      end else if (in_shift && sclk_fall) begin
         tx_shift <= (bit_cnt == 3'h0) ? spi_tx_byte : {tx_shift[SER_W-2:0], 1'h0};
      end
   end

   // Output data drives only while selected, never during reset, so the strap reads clean.
   assign serial_data_out_o = tx_shift[SER_W-1]; // [R9]
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         serial_data_out_oe <= 1'h0;
      end else begin
         serial_data_out_oe <= (next_ser_state == HPS_SER_SHIFT) && !sel_s; // [R7]
      end
   end

   // MIIM: clock and data levels go to the management engine, which owns the turnaround.
   assign miim_mdc = sclk_s; // [R10]
   assign miim_mdio_in = sdi_s; // [R11]
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         serial_slave_data_in_o <= 1'h0;
         serial_slave_data_in_oe <= 1'h0;
      end else begin
         serial_slave_data_in_o <= miim_out; // [R11]
         serial_slave_data_in_oe <= in_miim && miim_mode && miim_drive; // [R11]
      end
   end

   // Open-drain interrupt: pull low while any status bit is set.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         host_irq_n_o <= 1'h0;
         host_irq_n_oe <= 1'h0;
      end else begin
         host_irq_n_o <= 1'h0;
         host_irq_n_oe <= irq_any; // [R12]
      end
   end

   // Checks.
   property p_col_mac_input;
      @(posedge core_clk) disable iff (!rst_n) mii_mac |=> !col_oe;
   endproperty
   a_col_mac_input: assert property (p_col_mac_input) else $error("collision pin driven in MAC mode"); // [R1]

   property p_col_phy_output;
      @(posedge core_clk) disable iff (!rst_n)
         mii_phy |=> col_oe && (col_o == $past(mac_col));
   endproperty
   a_col_phy_output: assert property (p_col_phy_output) else $error("collision not driven in PHY mode"); // [R1]

   property p_rxclk_phy_toggles;
      @(posedge core_clk) disable iff (!rst_n)
         (mii_phy && speed_100)[*8] |-> rx_clk_oe && ($changed(rx_clk_o) ||
            ($past(rx_clk_o) != $past(rx_clk_o, 2)) || ($past(rx_clk_o, 2) != $past(rx_clk_o, 3)));
   endproperty
   a_rxclk_phy_toggles: assert property (p_rxclk_phy_toggles) else $error("receive clock stalled in PHY mode"); // [R2]

   property p_rxclk_mac_input;
      @(posedge core_clk) disable iff (!rst_n) mii_mac |=> !rx_clk_oe;
   endproperty
   a_rxclk_mac_input: assert property (p_rxclk_mac_input) else $error("receive clock driven in MAC mode"); // [R2]

   property p_pin_ten;
      @(posedge core_clk) disable iff (!rst_n)
         rmii_mode |=> (col_o == $past(gio.pad_o[GP_TEN])) && (col_oe == $past(gio.pad_oe[GP_TEN]));
   endproperty
   a_pin_ten: assert property (p_pin_ten) else $error("collision pin not acting as pin ten"); // [R3]
   property p_pin_seven;
      @(posedge core_clk) disable iff (!rst_n)
         rmii_mode |=> (rx_clk_o == $past(gio.pad_o[GP_SEVEN])) && (rx_clk_oe == $past(gio.pad_oe[GP_SEVEN]));
   endproperty
   a_pin_seven: assert property (p_pin_seven) else $error("receive clock pin not acting as pin seven"); // [R4]

   property p_strap_hold;
      @(posedge core_clk) rst_n && $past(rst_n) |-> $stable(mii_phy_mode) && $stable(clk_src_ref50);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset"); // [R18]
   property p_deselect_hiz;
      @(posedge core_clk) disable iff (!rst_n) sel_s |=> !serial_data_out_oe;
   endproperty
   a_deselect_hiz: assert property (p_deselect_hiz) else $error("serial output driven while deselected"); // [R7]

   property p_start_on_fall;
      @(posedge core_clk) disable iff (!rst_n) spi_xfer_start |-> $past(sel_prev) && !$past(sel_s);
   endproperty
   a_start_on_fall: assert property (p_start_on_fall) else $error("transfer start without select fall"); // [R8]

   property p_irq_follows;
      @(posedge core_clk) disable iff (!rst_n)
         irq_any ##1 irq_any |-> host_irq_n_oe && !host_irq_n_o;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt pin not pulled low"); // [R12]

   property p_mdio_drive;
      @(posedge core_clk) disable iff (!rst_n)
         (in_miim && miim_mode && miim_drive) |=> serial_slave_data_in_oe;
   endproperty
   a_mdio_drive: assert property (p_mdio_drive) else $error("MDIO not driven on request"); // [R11]

   c_byte_done: cover property (@(posedge core_clk) disable iff (!rst_n) spi_rx_valid);
   c_rmii_pin_ten: cover property (@(posedge core_clk) disable iff (!rst_n) rmii_mode && col_oe);
   c_phy_clock: cover property (@(posedge core_clk) disable iff (!rst_n) mii_phy && $rose(rx_clk_o));
   c_irq: cover property (@(posedge core_clk) disable iff (!rst_n) host_irq_n_oe);

endmodule // hps_top
`default_nettype wire

/* hps_host_model.sv */
// Host processor model for the serial slave port and the far-side receive clock.
`timescale 1ns/10ps
`default_nettype none
module hps_host_model (
   input wire logic core_clk,
   input wire logic sdo,
   input wire logic rx_clk_run,
   output var logic sel_n,
   output var logic sclk,
   output var logic sdi,
   output var logic rx_clk
);
   logic tog = 1'h0; // Free 25 MHz source.
   // The source reaches the pin only while the far side owns it.
   always #20 tog = ~tog;
   assign rx_clk = rx_clk_run & tog;
   // Idle: deselected, clock low, data released to its pull-up.
   initial begin
      sel_n = 1'h1;
      sclk = 1'h0;
      sdi = 1'h1;
   end
   // One mode 0 byte, MSB first; slow halves leave room for the pin synchronisers.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      @(posedge core_clk);
      sel_n <= 1'h0;
      for (int i = 7; i >= 0; i--) begin
         repeat (8) @(posedge core_clk);
         sdi <= tx[i];
         repeat (8) @(posedge core_clk);
         sclk <= 1'h1;
         rx[i] = sdo;
         repeat (8) @(posedge core_clk);
         sclk <= 1'h0;
      end
      repeat (8) @(posedge core_clk);
      sel_n <= 1'h1;
      sdi <= 1'h1;
   endtask
endmodule // hps_host_model
`default_nettype wire

/* test_hps_top.sv */
// Self-checking bench for the host-side pin function select block.
`timescale 1ns/10ps
`default_nettype none
module test_hps_top;
   import hps_pkg::*;
   // Levels the bench puts on the block, all set at time zero.
   logic core_clk = 1'h0, ptp_clk = 1'h0, rst_n = 1'h0, rmii_variant = 1'h0, speed_100 = 1'h1;
   logic rx_dv_i = 1'h1, strap_sdo = 1'h1, mac_col = 1'h0, miim_mode = 1'h0;
   logic miim_drive = 1'h0, miim_out = 1'h0;
   logic [7:0] spi_tx_byte = 8'h3c;
   logic [15:0] irq_status = 16'h0;
   logic [4:0] gp_dir = 5'h0, gp_src_trig = 5'h0, gp_host_out = 5'h0, gp_trig_level = 5'h0;
   logic [2:0] gin = 3'h0; // External levels on pins zero, eight and eleven.
   // Outputs of the block and of the host model.
   logic mii_phy_mode, clk_src_ref50, col_o, col_oe, col_in_seen, rx_clk_o, rx_clk_oe;
   logic rx_clk_in_seen, serial_slave_data_in_o, serial_slave_data_in_oe, serial_data_out_o;
   logic serial_data_out_oe, miim_mdc, miim_mdio_in, spi_xfer_start, spi_rx_valid;
   logic host_irq_n_o, host_irq_n_oe, general_pin_zero_o, general_pin_zero_oe;
   logic general_pin_eight_o, general_pin_eight_oe, general_pin_eleven_o, general_pin_eleven_oe;
   logic [7:0] spi_rx_byte, got, host_got;
   logic [4:0] gp_level, gp_ptp_level;
   logic serial_slave_select_n, serial_clk_i, host_sdi, host_rx_clk;
   int err_count = 0, check_count = 0, starts = 0, valids = 0, rises;
   // Pad levels: the driver wins, else the far side or the pull resistor.
   wire col_i = col_oe ? col_o : 1'h0;
   wire rx_clk_i = rx_clk_oe ? rx_clk_o : host_rx_clk;
   wire serial_data_out_i = serial_data_out_oe ? serial_data_out_o : strap_sdo;
   wire serial_slave_data_in_i = serial_slave_data_in_oe ? serial_slave_data_in_o : host_sdi;
   wire general_pin_zero_i = general_pin_zero_oe ? general_pin_zero_o : gin[0];
   wire general_pin_eight_i = general_pin_eight_oe ? general_pin_eight_o : gin[1];
   wire general_pin_eleven_i = general_pin_eleven_oe ? general_pin_eleven_o : gin[2];
   hps_top dut (.*);
   hps_host_model host (.core_clk(core_clk), .sdo(serial_data_out_i),
      .rx_clk_run(!mii_phy_mode && !rmii_variant), .sel_n(serial_slave_select_n),
      .sclk(serial_clk_i), .sdi(host_sdi), .rx_clk(host_rx_clk));
   // Core clock, and a precision-time clock offset in phase from it.
   always #4 core_clk = ~core_clk;
   initial begin
      #3;
      forever #32 ptp_clk = ~ptp_clk;
   end
   // Pulses stand one cycle, so each is counted once here.
   always @(posedge core_clk) begin
      if (spi_xfer_start === 1'h1) starts <= starts + 1;
      if (spi_rx_valid === 1'h1) valids <= valids + 1;
      if (spi_rx_valid === 1'h1) got <= spi_rx_byte;
   end
   // Compare one value and count it.
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // Wait for edges, then step past them so registered outputs have settled.
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Reset with the given straps held steady for the whole reset.
   task automatic do_reset(input logic rmii, input logic dv, input logic sdo);
      @(posedge core_clk);
      rst_n <= 1'h0;
      rmii_variant <= rmii;
      rx_dv_i <= dv;
      strap_sdo <= sdo;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'h1;
      step(3);
   endtask
   // Count rising edges of the driven receive clock over n cycles.
   task automatic count_rise(input int n, output int r);
      logic p;
      r = 0;
      p = rx_clk_o;
      repeat (n) begin
         step(1);
         if (rx_clk_o && !p) r++;
         p = rx_clk_o;
      end
   endtask
   // Print the counts and the verdict, then stop.
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // A hang counts as a mismatch.
   initial begin
      #100000;
      err_count++;
      final_report;
   end
   initial begin
      do_reset(1'h0, 1'h1, 1'h1);
      chk("phy_mode", mii_phy_mode, 1'h1);
      chk("ref50", clk_src_ref50, 1'h0);
      chk("col_oe", col_oe, 1'h1);
      chk("rxclk_oe", rx_clk_oe, 1'h1);
      chk("sdo_oe", serial_data_out_oe, 1'h0);
      @(posedge core_clk);
      mac_col <= 1'h1;
      rx_dv_i <= 1'h0;
      irq_status <= 16'h0100;
      step(2);
      chk("col_o", col_o, 1'h1);
      chk("irq", {host_irq_n_oe, host_irq_n_o}, 2'h2);
      step(3);
      chk("col_seen", col_in_seen, 1'h1);
      chk("held", mii_phy_mode, 1'h1);
      count_rise(50, rises);
      chk("rise25", rises, 10);
      @(posedge core_clk);
      speed_100 <= 1'h0;
      irq_status <= 16'h0;
      step(60);
      chk("irq_oe", host_irq_n_oe, 1'h0);
      count_rise(100, rises);
      chk("rise2m5", rises, 2);
      host.xfer(8'ha5, host_got);
      step(8);
      chk("rx_byte", got, 8'ha5);
      chk("tx_byte", host_got, 8'h3c);
      chk("starts", starts, 1);
      chk("valids", valids, 1);
      chk("sdo_oe", serial_data_out_oe, 1'h0);
      @(posedge core_clk);
      miim_mode <= 1'h1;
      miim_drive <= 1'h1;
      step(6);
      chk("mdio", {serial_slave_data_in_oe, miim_mdio_in}, 2'h2);
      @(posedge core_clk);
      miim_drive <= 1'h0;
      host.xfer(8'h5a, host_got);
      step(3);
      chk("mdio_rel", miim_mdio_in, 1'h1);
      chk("starts", starts, 1);
      $display("test phy_mii done");
      do_reset(1'h0, 1'h0, 1'h1);
      chk("mac", {mii_phy_mode, col_oe, rx_clk_oe}, 3'h0);
      $display("test mac_mii done");
      do_reset(1'h1, 1'h0, 1'h0);
      chk("ref50", clk_src_ref50, 1'h1);
      @(posedge core_clk);
      gp_dir <= 5'h1f;
      gp_host_out <= 5'h0a;
      gp_src_trig <= 5'h10;
      gp_trig_level <= 5'h10;
      step(8);
      chk("pin_ten", {col_oe, col_o}, 2'h3);
      chk("pin_seven", {rx_clk_oe, rx_clk_o}, 2'h3);
      chk("pins_o", {general_pin_eleven_o, general_pin_eight_o, general_pin_zero_o}, 3'h4);
      chk("level", gp_level, 5'h1a);
      @(posedge core_clk);
      gp_dir <= 5'h0;
      gin <= 3'h5;
      step(40);
      chk("oe", {general_pin_eleven_oe, general_pin_eight_oe, col_oe}, 3'h0);
      chk("level", gp_level, 5'h11);
      chk("ptp_level", gp_ptp_level, 5'h11);
      $display("test rmii_gpio done");
      final_report;
   end
endmodule // test_hps_top
`default_nettype wire
